// File: include/sct_link_if.sv
// Purpose: key-sector command link between controller and drive logic
// Assumes: both ends on aclk
// Notes:   one command and one answer outstanding at a time
`timescale 1ns/1ps
`default_nettype none

interface sct_link_if;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [15:0] w_action;
	logic [15:0] w_func;
	logic [15:0] w_sel;
	logic [15:0] w_value;
	logic [15:0] w_flags;
	logic        rsp_valid;
	logic        rsp_ready;
	logic [7:0]  rsp_error;
	logic [7:0]  rsp_count;
	logic [7:0]  rsp_number;
	logic [7:0]  rsp_status;
	logic        hard_reset;

	modport host (
		output cmd_valid, w_action, w_func, w_sel, w_value, w_flags,
		output rsp_ready, hard_reset,
		input  cmd_ready, rsp_valid, rsp_error, rsp_count,
		input  rsp_number, rsp_status
	);

	modport dev (
		input  cmd_valid, w_action, w_func, w_sel, w_value, w_flags,
		input  rsp_ready, hard_reset,
		output cmd_ready, rsp_valid, rsp_error, rsp_count,
		output rsp_number, rsp_status
	);
endinterface : sct_link_if

`default_nettype wire

// File: include/sct_pkg.sv
// Purpose: shared constants and types for the recovery-timer and
//          feature-control key-sector command pair
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes:   controller register map lives here as well
`default_nettype none

package sct_pkg;

	////////////////////////////////////////////////////////////////////
	// key sector codes
	localparam logic [15:0] ACT_RECOVERY = 16'h0003;
	localparam logic [15:0] ACT_FEATURE  = 16'h0004;
	localparam logic [15:0] FN_SET       = 16'h0001;
	localparam logic [15:0] FN_GET       = 16'h0002;
	localparam logic [15:0] FN_FLAGS     = 16'h0003;
	localparam logic [15:0] SEL_READ     = 16'h0001;
	localparam logic [15:0] SEL_WRITE    = 16'h0002;
	localparam logic [15:0] FEAT_WCACHE  = 16'h0001;
	localparam logic [15:0] FEAT_REORDER = 16'h0002;
	localparam logic [15:0] FEAT_TEMPLOG = 16'h0003;
	localparam logic [15:0] WC_BY_SETF   = 16'h0001;
	localparam logic [15:0] WC_FORCE_ON  = 16'h0002;
	localparam logic [15:0] WC_FORCE_OFF = 16'h0003;
	localparam logic [15:0] RO_ENABLE    = 16'h0001;
	localparam logic [15:0] RO_DISABLE   = 16'h0002;
	localparam logic [15:0] TL_INVALID   = 16'h0000;
	localparam int          FLAG_PERSIST = 0;

	////////////////////////////////////////////////////////////////////
	// reset values and limits
	localparam logic [15:0] LIMIT_RESET  = 16'h0000;
	localparam logic [15:0] LIMIT_MIN    = 16'h0041;
	localparam logic [15:0] FEAT_RESET   = 16'h0001;

	////////////////////////////////////////////////////////////////////
	// task-file answers
	localparam logic [7:0] ERR_OK    = 8'h00;
	localparam logic [7:0] STS_OK    = 8'h50;
	localparam logic [7:0] ERR_ABORT = 8'h04;
	localparam logic [7:0] STS_ERR   = 8'h51;
	localparam logic [7:0] TF_RSVD   = 8'h00;

	////////////////////////////////////////////////////////////////////
	// timing
	localparam int UNIT_MS     = 100;
	localparam int CLK_MHZ     = 100;
	localparam int UNIT_CYCLES = UNIT_MS * 1000 * CLK_MHZ;

	////////////////////////////////////////////////////////////////////
	// command classes seen by the recovery timer
	typedef enum logic [1:0] {
		KIND_NONQUEUED = 2'b00,
		KIND_QUEUED_IO = 2'b01,
		KIND_QUEUED_OO = 2'b10,
		KIND_STREAM    = 2'b11
	} cmd_kind_t;

	////////////////////////////////////////////////////////////////////
	// controller register map (byte offsets)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ACTION = 8'h04;
	localparam logic [7:0] REG_FUNC   = 8'h08;
	localparam logic [7:0] REG_SEL    = 8'h0C;
	localparam logic [7:0] REG_VALUE  = 8'h10;
	localparam logic [7:0] REG_FLAGS  = 8'h14;
	localparam logic [7:0] REG_RESULT = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	localparam logic [7:0] REG_ISTAT  = 8'h20;
	localparam logic [7:0] REG_IMASK  = 8'h24;
	localparam int CTRL_GO     = 0;
	localparam int CTRL_HRESET = 1;
	localparam int INT_DONE    = 0;
	localparam int INT_ERROR   = 1;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : sct_pkg

`default_nettype wire

// File: logic/recovery_timer.sv
// Purpose: counts one error-recovery limit in 100 ms units
// Assumes: start and stop are one-cycle pulses on aclk
// Notes:   a limit of zero never expires
`timescale 1ns/1ps
`default_nettype none

module recovery_timer #(
	parameter int UNIT_CYCLES = sct_pkg::UNIT_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        start,
	input  wire logic        stop,
	input  wire logic [15:0] limit,
	output logic             expired
);

	typedef struct packed {
		logic        run;
		logic [31:0] pre;
		logic [15:0] units;
		logic [15:0] lim;
		logic        expired;
	} tmr_t;

	tmr_t s;
	tmr_t next_s;

	////////////////////////////////////////////////////////////////////
	// prescaler to 100 ms ticks, then unit count against the limit
	always_comb begin
		next_s = s;
		if (start) begin
			next_s.run     = (limit != sct_pkg::LIMIT_RESET);
			next_s.pre     = 32'h0;
			next_s.units   = 16'h0;
			next_s.lim     = limit;
			next_s.expired = 1'b0;
		end else if (stop) begin
			next_s.run = 1'b0;
		end else if (s.run) begin
			next_s.pre = s.pre + 32'h1;
			if (s.pre == 32'(UNIT_CYCLES - 1)) begin
				next_s.pre   = 32'h0;
				next_s.units = s.units + 16'h1;
				if (s.units + 16'h1 >= s.lim) begin
					next_s.expired = 1'b1;
					next_s.run     = 1'b0;
				end
			end
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign expired = s.expired;

endmodule : recovery_timer

`default_nettype wire

// File: logic/sct_drive.sv
// Purpose: drive-side decoder for recovery-limit and feature commands
// Assumes: key words arrive parallel on the link, same clock
// Notes:   nonvolatile copies survive a hard reset, not aresetn;
//          nv_save tells outside storage to keep a persistent state
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - action 0003h means recovery limit command
// - selection 0001h read timer, 0002h write
// - set value word 3, 100 ms units
// - abort set below 65 units
// - get returns limit low/high in count/number
// - recovery success gives error 00h, status 50h
// - nonqueued timing runs until host completion
// - queued in-order timing starts at execution
// - no timing for streaming or out-of-order queued
// - limits volatile, default zero means disabled
// - action 0004h means feature control command
// - function set, get state, get flags
// - word 2 feature, word 3 state value
// - flag bit 0 set keeps state persistently
// - flag bit 0 clear volatile, hard reset reverts
// - feature answers state or flags, status 50h
// - write cache modes 1,2,3, default 1
module sct_drive #(
	parameter int UNIT_CYCLES = sct_pkg::UNIT_CYCLES
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	sct_link_if.dev                  link,
	input  wire logic                op_issue,
	input  wire logic                op_exec,
	input  wire logic                op_done,
	input  wire logic                op_write,
	input  wire sct_pkg::cmd_kind_t  op_kind,
	output logic                     op_timeout,
	output logic [15:0]              read_limit,
	output logic [15:0]              write_limit,
	output logic [15:0]              wcache_mode,
	output logic [15:0]              reorder_state,
	output logic [15:0]              templog_interval,
	output logic                     nv_save,
	output logic [15:0]              nv_code,
	output logic [15:0]              nv_state
);

	////////////////////////////////////////////////////////////////////
	// types and helpers

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RESP = 1'b1
	} dev_state_t;

	typedef struct packed {
		dev_state_t       st;
		logic [7:0]       err;
		logic [7:0]       cnt;
		logic [7:0]       num;
		logic [7:0]       sts;
		logic [15:0]      rd_lim;
		logic [15:0]      wr_lim;
		logic [2:0][15:0] feat;
		logic [2:0][15:0] nv_feat;
		logic [2:0]       pflag;
		logic [2:0]       nv_pflag;
		logic             nv_save;
		logic [15:0]      nv_code;
		logic [15:0]      nv_state;
	} dev_t;

	dev_t s;
	dev_t next_s;

	// feature code to slot; 2'd3 marks an unknown code
	function automatic logic [1:0] feat_slot(input logic [15:0] code);
		unique case (code)
			sct_pkg::FEAT_WCACHE:  feat_slot = 2'd0;
			sct_pkg::FEAT_REORDER: feat_slot = 2'd1;
			sct_pkg::FEAT_TEMPLOG: feat_slot = 2'd2;
			default:               feat_slot = 2'd3;
		endcase
	endfunction : feat_slot

	// legal state value for a given feature slot
	function automatic logic state_ok(input logic [1:0] slot,
		input logic [15:0] v);
		unique case (slot)
			2'd0: state_ok = (v == sct_pkg::WC_BY_SETF) ||
				(v == sct_pkg::WC_FORCE_ON) ||
				(v == sct_pkg::WC_FORCE_OFF);
			2'd1: state_ok = (v == sct_pkg::RO_ENABLE) ||
				(v == sct_pkg::RO_DISABLE);
			2'd2: state_ok = (v != sct_pkg::TL_INVALID);
			default: state_ok = 1'b0;
		endcase
	endfunction : state_ok

	////////////////////////////////////////////////////////////////////
	// command decode and answer

	logic [1:0] slot;
	logic       sel_ok;
	logic [15:0] sel_lim;

	// decode of the word fields used by both commands
	always_comb begin
		slot    = feat_slot(link.w_sel);
		sel_ok  = (link.w_sel == sct_pkg::SEL_READ) ||
			(link.w_sel == sct_pkg::SEL_WRITE);
		sel_lim = (link.w_sel == sct_pkg::SEL_WRITE) ? s.wr_lim :
			s.rd_lim;
	end

	// next-state logic: one command, one answer
	always_comb begin
		next_s         = s;
		next_s.nv_save = 1'b0;
		if (link.hard_reset) begin
			next_s.rd_lim = sct_pkg::LIMIT_RESET;
			next_s.wr_lim = sct_pkg::LIMIT_RESET;
			next_s.feat   = s.nv_feat;
			next_s.pflag  = s.nv_pflag;
		end
		unique case (s.st)
			ST_IDLE: begin
				if (link.cmd_valid) begin
					next_s.st  = ST_RESP;
					// anything not matched below is aborted
					next_s.err = sct_pkg::ERR_ABORT;
					next_s.sts = sct_pkg::STS_ERR;
					next_s.cnt = sct_pkg::TF_RSVD;
					next_s.num = sct_pkg::TF_RSVD;
					if (link.w_action == sct_pkg::ACT_RECOVERY &&
						sel_ok) begin
						if (link.w_func == sct_pkg::FN_SET &&
							link.w_value >= sct_pkg::LIMIT_MIN) begin
							next_s.err = sct_pkg::ERR_OK;
							next_s.sts = sct_pkg::STS_OK;
							if (link.w_sel == sct_pkg::SEL_WRITE) begin
								next_s.wr_lim = link.w_value;
							end else begin
								next_s.rd_lim = link.w_value;
							end
						end else if (link.w_func == sct_pkg::FN_GET) begin
							next_s.err = sct_pkg::ERR_OK;
							next_s.sts = sct_pkg::STS_OK;
							next_s.cnt = sel_lim[7:0];
							next_s.num = sel_lim[15:8];
						end
					end else if (link.w_action == sct_pkg::ACT_FEATURE &&
						slot != 2'd3) begin
						if (link.w_func == sct_pkg::FN_SET &&
							state_ok(slot, link.w_value)) begin
							next_s.err = sct_pkg::ERR_OK;
							next_s.sts = sct_pkg::STS_OK;
							next_s.feat[slot] = link.w_value;
							next_s.pflag[slot] =
								link.w_flags[sct_pkg::FLAG_PERSIST];
							if (link.w_flags[sct_pkg::FLAG_PERSIST]) begin
								next_s.nv_feat[slot]  = link.w_value;
								next_s.nv_pflag[slot] = 1'b1;
								next_s.nv_save  = 1'b1;
								next_s.nv_code  = link.w_sel;
								next_s.nv_state = link.w_value;
							end
						end else if (link.w_func == sct_pkg::FN_GET) begin
							next_s.err = sct_pkg::ERR_OK;
							next_s.sts = sct_pkg::STS_OK;
							next_s.cnt = s.feat[slot][7:0];
							next_s.num = s.feat[slot][15:8];
						end else if (link.w_func == sct_pkg::FN_FLAGS) begin
							next_s.err = sct_pkg::ERR_OK;
							next_s.sts = sct_pkg::STS_OK;
							// only the persist bit is defined
							next_s.cnt = {7'h00, s.pflag[slot]};
							next_s.num = 8'h00;
						end
					end
				end
			end
			ST_RESP: begin
				if (link.rsp_ready) begin
					next_s.st = ST_IDLE;
				end
			end
		endcase
	end

	// state register; aresetn stands for a power cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s          <= '0;
			s.st       <= ST_IDLE;
			s.rd_lim   <= sct_pkg::LIMIT_RESET;
			s.wr_lim   <= sct_pkg::LIMIT_RESET;
			s.feat     <= {3{sct_pkg::FEAT_RESET}};
			s.nv_feat  <= {3{sct_pkg::FEAT_RESET}};
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////
	// link and user outputs

	assign link.cmd_ready  = (s.st == ST_IDLE);
	assign link.rsp_valid  = (s.st == ST_RESP);
	assign link.rsp_error  = s.err;
	assign link.rsp_count  = s.cnt;
	assign link.rsp_number = s.num;
	assign link.rsp_status = s.sts;

	assign read_limit       = s.rd_lim;
	assign write_limit      = s.wr_lim;
	assign wcache_mode      = s.feat[0];
	assign reorder_state    = s.feat[1];
	assign templog_interval = s.feat[2];
	assign nv_save          = s.nv_save;
	assign nv_code          = s.nv_code;
	assign nv_state         = s.nv_state;

	////////////////////////////////////////////////////////////////////
	// recovery timing of host commands

	logic timer_start;

	// start point depends on command class
	always_comb begin
		unique case (op_kind)
			sct_pkg::KIND_NONQUEUED: timer_start = op_issue;
			sct_pkg::KIND_QUEUED_IO: timer_start = op_exec;
			sct_pkg::KIND_QUEUED_OO: timer_start = 1'b0;
			sct_pkg::KIND_STREAM:    timer_start = 1'b0;
		endcase
	end

	// one timer; the command's direction picks the limit
	recovery_timer #(
		.UNIT_CYCLES (UNIT_CYCLES)
	) u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (timer_start),
		.stop    (op_done),
		.limit   (op_write ? s.wr_lim : s.rd_lim),
		.expired (op_timeout)
	);

endmodule : sct_drive

`default_nettype wire

// File: logic/sct_host.sv
// Purpose: controller that sends key sectors on software's order
// Assumes: AXI4-Lite slave, 32-bit data, one aclk
// Notes:   done and error events raise a masked level interrupt
`timescale 1ns/1ps
`default_nettype none

module sct_host (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	sct_link_if.host         link,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             irq
);

	typedef struct packed {
		logic [15:0] act;
		logic [15:0] fn;
		logic [15:0] sel;
		logic [15:0] val;
		logic [15:0] flg;
		logic [31:0] result;
		logic        pend;
		logic        busy;
		logic        hreset;
		logic [1:0]  istat;
		logic [1:0]  imask;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} host_t;

	host_t s;
	host_t next_s;
	logic  wr_go;

	// byte-lane merge of a write into a 16-bit register
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] be);
		merge = old;
		if (be[0]) merge[7:0]  = d[7:0];
		if (be[1]) merge[15:8] = d[15:8];
	endfunction : merge

	////////////////////////////////////////////////////////////////////
	// bus, command launch and result capture

	assign wr_go = awvalid && wvalid && !s.bvalid;

	always_comb begin
		next_s        = s;
		next_s.hreset = 1'b0;
		if (s.bvalid && bready) next_s.bvalid = 1'b0;
		if (s.rvalid && rready) next_s.rvalid = 1'b0;
		if (s.pend && link.cmd_ready) next_s.pend = 1'b0;
		// register writes, clears before event sets
		if (wr_go) begin
			next_s.bvalid = 1'b1;
			next_s.bresp  = sct_pkg::RESP_OKAY;
			unique case (awaddr)
				sct_pkg::REG_CTRL: begin
					if (wstrb[0] && wdata[sct_pkg::CTRL_GO] && !s.busy) begin
						next_s.pend = 1'b1;
						next_s.busy = 1'b1;
					end
					if (wstrb[0] && wdata[sct_pkg::CTRL_HRESET]) begin
						next_s.hreset = 1'b1;
					end
				end
				sct_pkg::REG_ACTION: next_s.act = merge(s.act, wdata, wstrb);
				sct_pkg::REG_FUNC:   next_s.fn = merge(s.fn, wdata, wstrb);
				sct_pkg::REG_SEL:    next_s.sel = merge(s.sel, wdata, wstrb);
				sct_pkg::REG_VALUE:  next_s.val = merge(s.val, wdata, wstrb);
				sct_pkg::REG_FLAGS:  next_s.flg = merge(s.flg, wdata, wstrb);
				sct_pkg::REG_ISTAT: begin
					if (wstrb[0]) next_s.istat = s.istat & ~wdata[1:0];
				end
				sct_pkg::REG_IMASK: begin
					if (wstrb[0]) next_s.imask = wdata[1:0];
				end
				sct_pkg::REG_RESULT, sct_pkg::REG_STATUS: ;
				default: next_s.bresp = sct_pkg::RESP_SLVERR;
			endcase
		end
		// answer from the drive; sets win over a same-cycle clear
		if (link.rsp_valid && s.busy && !s.pend) begin
			next_s.busy   = 1'b0;
			next_s.result = {link.rsp_status, link.rsp_number,
				link.rsp_count, link.rsp_error};
			next_s.istat[sct_pkg::INT_DONE] = 1'b1;
			if (link.rsp_status != sct_pkg::STS_OK) begin
				next_s.istat[sct_pkg::INT_ERROR] = 1'b1;
			end
		end
		// register reads
		if (arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = sct_pkg::RESP_OKAY;
			next_s.rdata  = 32'h0000_0000;
			unique case (araddr)
				sct_pkg::REG_CTRL:   ;
				sct_pkg::REG_ACTION: next_s.rdata[15:0] = s.act;
				sct_pkg::REG_FUNC:   next_s.rdata[15:0] = s.fn;
				sct_pkg::REG_SEL:    next_s.rdata[15:0] = s.sel;
				sct_pkg::REG_VALUE:  next_s.rdata[15:0] = s.val;
				sct_pkg::REG_FLAGS:  next_s.rdata[15:0] = s.flg;
				sct_pkg::REG_RESULT: next_s.rdata = s.result;
				sct_pkg::REG_STATUS: next_s.rdata[0] = s.busy;
				sct_pkg::REG_ISTAT:  next_s.rdata[1:0] = s.istat;
				sct_pkg::REG_IMASK:  next_s.rdata[1:0] = s.imask;
				default: next_s.rresp = sct_pkg::RESP_SLVERR;
			endcase
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign awready = wr_go;
	assign wready  = wr_go;
	assign bvalid  = s.bvalid;
	assign bresp   = s.bresp;
	assign arready = !s.rvalid;
	assign rvalid  = s.rvalid;
	assign rresp   = s.rresp;
	assign rdata   = s.rdata;
	assign irq     = |(s.istat & s.imask);

	// key words go out in their sector positions
	assign link.cmd_valid  = s.pend;
	assign link.w_action   = s.act;
	assign link.w_func     = s.fn;
	assign link.w_sel      = s.sel;
	assign link.w_value    = s.val;
	assign link.w_flags    = s.flg;
	assign link.rsp_ready  = s.busy && !s.pend;
	assign link.hard_reset = s.hreset;

endmodule : sct_host

`default_nettype wire

// File: sim/sct_link_sva.sv
// Purpose: checks the key-sector link between the two ends
// Assumes: one clock aclk, synchronous active-low reset
// Notes:   watches the link signals as plain inputs
`timescale 1ns/1ps
`default_nettype none
module sct_link_sva (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire logic [15:0] w_action,
	input wire logic [15:0] w_func,
	input wire logic [15:0] w_sel,
	input wire logic [15:0] w_value,
	input wire logic        rsp_valid,
	input wire logic        rsp_ready,
	input wire logic [7:0]  rsp_error,
	input wire logic [7:0]  rsp_count,
	input wire logic [7:0]  rsp_status
);
	////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// command taken, recovery command taken, timer selection legal
	wire logic tk = cmd_valid && cmd_ready;
	wire logic rc = tk && w_action == 16'h0003;
	wire logic gs = w_sel == 16'h0001 || w_sel == 16'h0002;
	rsp_next_a: assert property (tk |=> rsp_valid)
		else $error("no answer one cycle after take");
	one_cmd_a: assert property (rsp_valid |-> !cmd_ready)
		else $error("command taken while answer pending");
	rsp_hold_a: assert property (rsp_valid && !rsp_ready
		|=> rsp_valid && $stable(rsp_status)) else $error("answer moved");
	ok_error_a: assert property (
		rsp_valid && rsp_status == 8'h50 |-> rsp_error == 8'h00)
		else $error("success with nonzero error");
	min_limit_a: assert property (
		rc && w_func == 16'h0001 && gs && w_value < 16'h0041
		|=> rsp_status == 8'h51) else $error("short limit accepted");
	set_ok_a: assert property (
		rc && w_func == 16'h0001 && gs && w_value >= 16'h0041
		|=> rsp_status == 8'h50) else $error("legal limit refused");
	bad_sel_a: assert property (rc && !gs
		|=> rsp_status == 8'h51) else $error("bad selection accepted");
	bad_action_a: assert property (
		tk && w_action != 16'h0003 && w_action != 16'h0004
		|=> rsp_error == 8'h04) else $error("bad action accepted");
	bad_func_a: assert property (
		tk && w_action == 16'h0004 && (w_func == 16'h0000 ||
		w_func > 16'h0003) |=> rsp_status == 8'h51 && rsp_count == 8'h00)
		else $error("bad feature function accepted");
	cover property (rc ##1 rsp_status == 8'h50);
	cover property (tk && w_action == 16'h0004 && w_func == 16'h0003);
	cover property (tk ##1 rsp_status == 8'h51);
endmodule : sct_link_sva
`default_nettype wire

// File: sim/tb_top.sv
// Purpose: drives both ends over the register bus and timer inputs
// Assumes: 100 MHz aclk, timer unit shortened to 4 cycles
// Notes:   read results are compared from a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int UC = 4;
	logic              aclk, aresetn, awvalid, awready, wvalid, wready;
	logic              bvalid, bready, arvalid, arready, rvalid, rready;
	logic              irq, op_issue, op_exec, op_done, op_write, op_timeout;
	logic [7:0]        awaddr, araddr;
	logic [31:0]       wdata, rdata, seed;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	sct_pkg::cmd_kind_t op_kind;
	logic [15:0]       v, k;
	logic [33:0]       q[$];
	int                err_total, compares, cyc;
	localparam logic [31:0] ABT = {8'h51, 16'h0000, 8'h04};
	sct_link_if link ();
	sct_host u_sct_host (.aclk, .aresetn, .link, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);
	sct_drive #(.UNIT_CYCLES(UC)) u_sct_drive (.aclk, .aresetn, .link,
		.op_issue, .op_exec, .op_done, .op_write, .op_kind, .op_timeout,
		.read_limit(), .write_limit(), .wcache_mode(), .reorder_state(),
		.templog_interval(), .nv_save(), .nv_code(), .nv_state());
	sct_link_sva u_sct_link_sva (.aclk, .aresetn, .cmd_valid(link.cmd_valid),
		.cmd_ready(link.cmd_ready), .w_action(link.w_action),
		.w_func(link.w_func), .w_sel(link.w_sel), .w_value(link.w_value),
		.rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
		.rsp_error(link.rsp_error), .rsp_count(link.rsp_count),
		.rsp_status(link.rsp_status));
	////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	// success answer: {status, number, count, error}
	function automatic logic [31:0] ok(input logic [15:0] d);
		return {8'h50, d[15:8], d[7:0], 8'h00};
	endfunction : ok
	task automatic conclude();
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [33:0] g, input logic [33:0] x);
		compares++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	// bus master: write and read, each held until its ready
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		// offsets above the last register answer with a slave error
		q.push_back({32'h0, (a > sct_pkg::REG_IMASK) ? sct_pkg::RESP_SLVERR :
			sct_pkg::RESP_OKAY});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(posedge aclk);
		while (!(awready && wready)) @(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(posedge aclk);
		while (!bvalid) @(posedge aclk);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] x);
		@(posedge aclk);
		q.push_back(x);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		while (!arready) @(posedge aclk);
		arvalid <= 1'b0;
		@(posedge aclk);
		while (!rvalid) @(posedge aclk);
		rready <= 1'b0;
	endtask : rd
	// one key sector, wait for the done interrupt, clear it, read result
	task automatic cmd(input logic [15:0] a, input logic [15:0] f,
		input logic [15:0] s, input logic [15:0] d, input logic [15:0] fl,
		input logic [31:0] x);
		int n;
		wr(sct_pkg::REG_ACTION, {16'h0000, a});
		wr(sct_pkg::REG_FUNC, {16'h0000, f});
		wr(sct_pkg::REG_SEL, {16'h0000, s});
		wr(sct_pkg::REG_VALUE, {16'h0000, d});
		wr(sct_pkg::REG_FLAGS, {16'h0000, fl});
		wr(sct_pkg::REG_CTRL, 32'h1);
		n = 0;
		while (irq !== 1'b1 && n < 50) begin
			@(posedge aclk);
			n++;
		end
		wr(sct_pkg::REG_ISTAT, 32'h3);
		rd(sct_pkg::REG_RESULT, {2'h0, x});
	endtask : cmd
	// pulse issue, exec or done (3 gives none), wait, check timeout flag
	task automatic pulse(input int p, input int w, input logic x);
		@(posedge aclk);
		{op_done, op_exec, op_issue} <= 3'h1 << p;
		@(posedge aclk);
		{op_done, op_exec, op_issue} <= 3'h0;
		repeat (w) @(posedge aclk);
		chk({33'h0, op_timeout}, {33'h0, x});
	endtask : pulse
	////////////////////////////////////////
	// result monitor takes the oldest expectation, read or write answer
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready && q.size() > 0)
			chk({rresp, rdata}, q.pop_front());
		if (bvalid === 1'b1 && bready && q.size() > 0)
			chk({32'h0, bresp}, q.pop_front());
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{op_issue, op_exec, op_done, op_write} = 4'h0;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		op_kind = sct_pkg::KIND_STREAM;
		seed = 32'hDB8D;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(sct_pkg::REG_IMASK, 34'h0);
		rd(sct_pkg::REG_STATUS, 34'h0);
		rd(8'h30, {sct_pkg::RESP_SLVERR, 32'h0});
		wr(8'h30, 32'h1);
		wr(sct_pkg::REG_IMASK, 32'h1);
		cmd(16'h3, 16'h2, 16'h1, 16'h0, 16'h0, ok(16'h0));
		cmd(16'h3, 16'h1, 16'h1, 16'h40, 16'h0, ABT);
		cmd(16'h3, 16'h1, 16'h1, 16'h41, 16'h0, ok(16'h0));
		cmd(16'h3, 16'h2, 16'h1, 16'h0, 16'h0, ok(16'h41));
		seed = xs(seed);
		v = 16'h41 + {10'h000, seed[5:0]};
		cmd(16'h3, 16'h1, 16'h2, v, 16'h0, ok(16'h0));
		cmd(16'h3, 16'h2, 16'h2, 16'h0, 16'h0, ok(v));
		cmd(16'h3, 16'h1, 16'h3, v, 16'h0, ABT);
		cmd(16'h5, 16'h1, 16'h1, 16'h0, 16'h0, ABT);
		cmd(16'h4, 16'h5, 16'h1, 16'h0, 16'h0, ABT);
		cmd(16'h4, 16'h2, 16'h1, 16'h0, 16'h0, ok(16'h1));
		for (k = 16'h1; k <= 16'h3; k++) begin
			cmd(16'h4, 16'h1, 16'h1, k, 16'h0, ok(16'h0));
			cmd(16'h4, 16'h2, 16'h1, 16'h0, 16'h0, ok(k));
		end
		cmd(16'h4, 16'h1, 16'h1, 16'h4, 16'h0, ABT);
		cmd(16'h4, 16'h3, 16'h1, 16'h0, 16'h0, ok(16'h0));
		cmd(16'h4, 16'h1, 16'h1, 16'h2, 16'h1, ok(16'h0));
		cmd(16'h4, 16'h3, 16'h1, 16'h0, 16'h0, ok(16'h1));
		cmd(16'h4, 16'h1, 16'h1, 16'h3, 16'h0, ok(16'h0));
		pulse(0, 300, 1'b0);
		op_kind <= sct_pkg::KIND_QUEUED_OO;
		pulse(1, 300, 1'b0);
		op_kind <= sct_pkg::KIND_QUEUED_IO;
		pulse(0, 300, 1'b0);
		pulse(1, 65 * UC - 10, 1'b0);
		pulse(3, 20, 1'b1);
		op_kind <= sct_pkg::KIND_NONQUEUED;
		pulse(0, 65 * UC - 10, 1'b0);
		pulse(3, 20, 1'b1);
		pulse(0, 100, 1'b0);
		pulse(2, 300, 1'b0);
		// a write command times out against the random write limit
		op_write <= 1'b1;
		pulse(0, int'(v) * UC - 10, 1'b0);
		pulse(3, 20, 1'b1);
		wr(sct_pkg::REG_CTRL, 32'h2);
		cmd(16'h4, 16'h2, 16'h1, 16'h0, 16'h0, ok(16'h2));
		cmd(16'h3, 16'h2, 16'h1, 16'h0, 16'h0, ok(16'h0));
		wr(sct_pkg::REG_IMASK, 32'h0);
		wr(sct_pkg::REG_CTRL, 32'h1);
		repeat (10) @(posedge aclk);
		chk({33'h0, irq}, 34'h0);
		rd(sct_pkg::REG_ISTAT, 34'h1);
		wr(sct_pkg::REG_ISTAT, 32'h1);
		rd(sct_pkg::REG_ISTAT, 34'h0);
		// an aborted command sets both done and error bits
		wr(sct_pkg::REG_ACTION, 32'h5);
		wr(sct_pkg::REG_CTRL, 32'h1);
		repeat (10) @(posedge aclk);
		rd(sct_pkg::REG_ISTAT, 34'h3);
		conclude();
	end
endmodule : tb_top
`default_nettype wire
